// *** spdts_map.vh ***
// Constant map for the module-sensor two-wire target
`ifndef SPDTS_MAP_VH
`define SPDTS_MAP_VH
// Upper four bits of each bus target address
`define SPDTS_TS_ID     4'h3
`define SPDTS_ARR_ID    4'ha
`define SPDTS_PROT_ID   4'h6
// Select byte read/write bit position; clear bit position within the command field
`define SPDTS_RW_BIT    0
`define SPDTS_CLR_BIT   2
// Byte slot counts and transaction byte indices
`define SPDTS_BITS      4'h8
`define SPDTS_CNT0      4'h0
`define SPDTS_CNT1      4'h1
`define SPDTS_IDX_DEV   3'h0
`define SPDTS_IDX_PTR   3'h1
`define SPDTS_IDX_D0    3'h2
`define SPDTS_IDX_D1    3'h3
`define SPDTS_IDX_MAX   3'h7
// Thermal register indices
`define SPDTS_R_CAP     4'h0
`define SPDTS_R_CFG     4'h1
`define SPDTS_R_HI      4'h2
`define SPDTS_R_CRIT    4'h4
`define SPDTS_R_TEMP    4'h5
`define SPDTS_R_MID     4'h6
`define SPDTS_R_DID     4'h7
`define SPDTS_R_VEN     4'h8
// Reset values
`define SPDTS_CAP_RST   16'h00ff
`define SPDTS_VEN_RST   16'h0018
`define SPDTS_ZERO16    16'h0000
`define SPDTS_FILL      8'hff
`define SPDTS_PROT_RST  4'h0
`endif

// *** spdts_target.v ***
// Two-wire target: configuration array reads, write protection and thermal registers
`timescale 1ns/1ps
`include "spdts_map.vh"

// Overview of operation
// - Array reads ignore protection state entirely
// - Array counter advances after every read byte
// - Repeated read select acked, addressed byte returned
// - Current read returns counter byte, then increments
// - Host ack continues sequential read, no-ack ends
// - Counter wraps to location zero past end
// - Host no-ack in ninth slot idles array
// - Protect and data writes acked per protection
// - Status query acks instruction only when unprotected
// - Thermal set answers 0011 plus logical address
// - High-voltage pin disables logical address decode
// - Thermal registers 0x00-0x08 are 16-bit words
// - Invalid thermal indices answered with ack
// - Thermal write: pointer then two data bytes
// - Read select alone returns pointed register
// - Bytes move most significant bit first
// - Thermal read: host ack continues with next byte, no-ack ends
// - Array ignores bus during write cycle
module spdts_target #(
  parameter        AW        = 8,        // Array address width
  parameter        DEPTH     = 256,      // Array bytes
  parameter        NREG      = 9,        // Thermal registers
  parameter [19:0] WR_CYCLES = 20'h0_03e8, // Internal write cycle length in clocks
  parameter [15:0] MFR_ID    = 16'h0000, // Arbitrary value
  parameter [15:0] DEV_ID    = 16'h0000  // Arbitrary value
) (
  input  wire        CLK,          // 25 MHz clock
  input  wire        RSTN,         // Synchronous reset, active low
  input  wire        SCL_IN,       // Serial clock pin level
  input  wire        SDA_IN,       // Serial data pin level
  output wire        SDA_OUT,      // Serial data drive value, always low
  output wire        SDA_OE,       // High while pulling serial data low
  input  wire [2:0]  SA_PINS,      // Logical serial address straps
  input  wire        SA0_HV,       // First address pin at high voltage
  input  wire [15:0] AMBIENT_TEMP, // Temperature word from sensor logic
  output wire        ARRAY_BUSY,   // Internal array write cycle running
  output wire [15:0] TS_CONFIG     // Thermal configuration word
);

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_RX    = 6'h02;
  localparam [5:0] S_RXACK = 6'h04;
  localparam [5:0] S_TX    = 6'h08;
  localparam [5:0] S_TXACK = 6'h10;
  localparam [5:0] S_SPARE = 6'h20;
  localparam [1:0] T_NONE  = 2'h0;
  localparam [1:0] T_ARR   = 2'h1;
  localparam [1:0] T_PROT  = 2'h2;
  localparam [1:0] T_TS    = 2'h3;

  reg [2:0]    scl_sync_reg;
  reg [2:0]    sda_sync_reg;
  reg [1:0]    hv_sync_reg;
  reg [2:0]    sa_sync0_reg;
  reg [2:0]    sa_sync1_reg;
  reg [5:0]    state_reg;
  reg [3:0]    cnt_reg;
  reg [2:0]    idx_reg;
  reg [7:0]    sh_reg;
  reg [7:0]    tx_reg;
  reg [1:0]    tgt_reg;
  reg          rw_reg;
  reg [2:0]    cmd_reg;
  reg          pend_reg;
  reg          hack_reg;
  reg          hsel_reg;
  reg [AW-1:0] acnt_reg;
  reg [3:0]    ptr_reg;
  reg [7:0]    hold_reg;
  reg [3:0]    prot_reg;
  reg [19:0]   busy_cnt_reg;
  reg          oe_reg;
  reg          busy_reg;
  reg          sda_out_reg;
  reg          ack_next;
  reg [1:0]    tgt_next;
  reg [7:0]    nb_next;
  reg [15:0]   ts_rd_next;

  wire [8*DEPTH-1:0] mem_flat;
  wire [16*NREG-1:0] ts_flat;
  wire               scl_s   = scl_sync_reg[1];
  wire               sda_s   = sda_sync_reg[1];
  wire               scl_rise = scl_s & ~scl_sync_reg[2];
  wire               scl_fall = ~scl_s & scl_sync_reg[2];
  wire               start_ev = scl_s & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_s;
  wire               stop_ev  = scl_s & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_s;
  wire               byte_end = (state_reg == S_RX) & scl_fall & (cnt_reg == `SPDTS_BITS);
  wire               lsa_ok   = hv_sync_reg[1] | (sh_reg[3:1] == sa_sync1_reg);
  wire               arr_prot = prot_reg[{1'b0, acnt_reg[AW-1]}];
  wire               op_ok    = ~rw_reg & (cmd_reg[`SPDTS_CLR_BIT] | ~prot_reg[cmd_reg[1:0]]);
  wire               mem_we   = byte_end & (tgt_reg == T_ARR) & (idx_reg >= `SPDTS_IDX_D0) & ack_next;
  wire               ts_we    = byte_end & (tgt_reg == T_TS) & (idx_reg == `SPDTS_IDX_D1) & ack_next;
  wire [7:0]         arr_byte = mem_flat[acnt_reg*8 +: 8];

  assign SDA_OUT    = sda_out_reg;
  assign SDA_OE     = oe_reg;
  assign ARRAY_BUSY = busy_reg;
  assign TS_CONFIG  = ts_flat[16 +: 16];

  // Pin synchronisers; only the second stage onward feeds logic
  always @(posedge CLK) begin
    if (!RSTN) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      hv_sync_reg  <= 2'h0;
      sa_sync0_reg <= 3'h0;
      sa_sync1_reg <= 3'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
      hv_sync_reg  <= {hv_sync_reg[0], SA0_HV};
      sa_sync0_reg <= SA_PINS;
      sa_sync1_reg <= sa_sync0_reg;
    end
  end

  // Array cells; flip-flops, one generated entry per byte
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_mem
      localparam [AW-1:0] A = g;
      reg [7:0] cell_reg;
      always @(posedge CLK) begin
        if (!RSTN) begin
          cell_reg <= `SPDTS_FILL;
        end else if (mem_we && acnt_reg == A) begin
          cell_reg <= sh_reg;
        end
      end
      assign mem_flat[g*8 +: 8] = cell_reg;
    end
  endgenerate

  // Thermal words; read-only entries keep their reset value
  generate
    for (g = 0; g < NREG; g = g + 1) begin : g_ts
      localparam [3:0]  I  = g;
      localparam [15:0] RV = (I == `SPDTS_R_CAP) ? `SPDTS_CAP_RST :
                             (I == `SPDTS_R_MID) ? MFR_ID :
                             (I == `SPDTS_R_DID) ? DEV_ID :
                             (I == `SPDTS_R_VEN) ? `SPDTS_VEN_RST : `SPDTS_ZERO16;
      localparam        WR = (I == `SPDTS_R_VEN) ||
                             (I >= `SPDTS_R_CFG && I <= `SPDTS_R_CRIT);
      reg [15:0] word_reg;
      always @(posedge CLK) begin
        if (!RSTN) begin
          word_reg <= RV;
        end else if (WR && ts_we && ptr_reg == I) begin
          word_reg <= {hold_reg, sh_reg};
        end
      end
      assign ts_flat[g*16 +: 16] = word_reg;
    end
  endgenerate

  // Thermal read mux; temperature comes live, unknown indices read zero
  always @* begin
    ts_rd_next = `SPDTS_ZERO16;
    if (ptr_reg == `SPDTS_R_TEMP) begin
      ts_rd_next = AMBIENT_TEMP;
    end else if (ptr_reg < NREG) begin
      ts_rd_next = ts_flat[ptr_reg*16 +: 16];
    end
    nb_next = (tgt_reg == T_TS) ? (hsel_reg ? ts_rd_next[7:0] : ts_rd_next[15:8]) : arr_byte;
  end

  // Acknowledge decision for the byte just received
  always @* begin
    ack_next = 1'b0;
    tgt_next = tgt_reg;
    case (idx_reg)
      `SPDTS_IDX_DEV: begin
        if (sh_reg[7:4] == `SPDTS_TS_ID && lsa_ok) begin
          tgt_next = T_TS;
          ack_next = 1'b1;
        end else if (sh_reg[7:4] == `SPDTS_ARR_ID && lsa_ok && !busy_reg) begin
          tgt_next = T_ARR;
          ack_next = 1'b1;
        end else if (sh_reg[7:4] == `SPDTS_PROT_ID && !busy_reg) begin
          tgt_next = T_PROT;
          // Status query acks only if clear; set acks only if clear; clear-all always
          ack_next = (~sh_reg[`SPDTS_RW_BIT] & sh_reg[3]) | ~prot_reg[sh_reg[2:1]];
        end else begin
          tgt_next = T_NONE;
        end
      end
      `SPDTS_IDX_PTR: begin
        ack_next = (tgt_reg == T_PROT) ? op_ok : (tgt_reg != T_NONE);
      end
      default: begin
        case (tgt_reg)
          T_ARR:   ack_next = ~rw_reg & ~arr_prot;
          T_PROT:  ack_next = op_ok;
          T_TS:    ack_next = ~rw_reg & (idx_reg <= `SPDTS_IDX_D1);
          default: ack_next = 1'b0;
        endcase
      end
    endcase
  end

  // Bus sequencer
  always @(posedge CLK) begin
    if (!RSTN) begin
      state_reg    <= S_IDLE;
      cnt_reg      <= `SPDTS_CNT0;
      idx_reg      <= `SPDTS_IDX_DEV;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      tgt_reg      <= T_NONE;
      rw_reg       <= 1'b0;
      cmd_reg      <= 3'h0;
      pend_reg     <= 1'b0;
      hack_reg     <= 1'b0;
      hsel_reg     <= 1'b0;
      acnt_reg     <= {AW{1'b0}};
      ptr_reg      <= `SPDTS_R_CAP;
      hold_reg     <= 8'h00;
      prot_reg     <= `SPDTS_PROT_RST;
      busy_cnt_reg <= 20'h0_0000;
      busy_reg     <= 1'b0;
      oe_reg       <= 1'b0;
      sda_out_reg  <= 1'b0;
    end else begin
      // Write cycle timer; array stays deaf until it expires
      busy_reg <= (busy_cnt_reg != 20'h0_0000);
      if (busy_cnt_reg != 20'h0_0000) begin
        busy_cnt_reg <= busy_cnt_reg - 20'h0_0001;
      end
      if (start_ev) begin
        // Repeated start drops any pending write, keeps counter and pointer
        state_reg <= S_RX;
        cnt_reg   <= `SPDTS_CNT0;
        idx_reg   <= `SPDTS_IDX_DEV;
        oe_reg    <= 1'b0;
        pend_reg  <= 1'b0;
      end else if (stop_ev) begin
        state_reg <= S_IDLE;
        oe_reg    <= 1'b0;
        pend_reg  <= 1'b0;
        // Only a stop in the slot right after an ack starts the write cycle;
        // the stop's own clock rise has already been counted as one bit
        if (pend_reg && state_reg == S_RX && cnt_reg == `SPDTS_CNT1) begin
          busy_cnt_reg <= WR_CYCLES;
          busy_reg     <= 1'b1;
          if (tgt_reg == T_PROT) begin
            if (cmd_reg[`SPDTS_CLR_BIT]) begin
              prot_reg <= `SPDTS_PROT_RST;
            end else begin
              prot_reg[cmd_reg[1:0]] <= 1'b1;
            end
          end
        end
      end else begin
        case (state_reg)
          S_RX: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + `SPDTS_CNT1;
            end else if (byte_end) begin
              oe_reg    <= ack_next;
              tgt_reg   <= tgt_next;
              state_reg <= S_RXACK;
              if (idx_reg != `SPDTS_IDX_MAX) begin
                idx_reg <= idx_reg + 3'h1;
              end
              if (idx_reg == `SPDTS_IDX_DEV) begin
                rw_reg   <= sh_reg[`SPDTS_RW_BIT];
                cmd_reg  <= sh_reg[3:1];
                hsel_reg <= 1'b0;
              end else if (idx_reg == `SPDTS_IDX_PTR && !rw_reg) begin
                if (tgt_reg == T_ARR) begin
                  acnt_reg <= sh_reg[AW-1:0];
                end else if (tgt_reg == T_TS) begin
                  ptr_reg <= sh_reg[3:0];
                end else if (ack_next) begin
                  pend_reg <= 1'b0;
                end
              end else if (ack_next) begin
                if (tgt_reg == T_ARR) begin
                  acnt_reg <= acnt_reg + {{(AW-1){1'b0}}, 1'b1};
                  pend_reg <= 1'b1;
                end else if (tgt_reg == T_PROT) begin
                  pend_reg <= 1'b1;
                end else if (idx_reg == `SPDTS_IDX_D0) begin
                  hold_reg <= sh_reg;
                end
              end else if (tgt_reg == T_PROT || tgt_reg == T_ARR) begin
                pend_reg <= 1'b0;
              end
            end
          end
          S_RXACK: begin
            if (scl_fall) begin
              cnt_reg <= `SPDTS_CNT0;
              if (tgt_reg == T_NONE) begin
                oe_reg    <= 1'b0;
                state_reg <= S_IDLE;
              end else if (rw_reg && tgt_reg != T_PROT && idx_reg == `SPDTS_IDX_PTR) begin
                // First read byte goes out right after the select ack
                oe_reg    <= ~nb_next[7];
                tx_reg    <= {nb_next[6:0], 1'b0};
                hsel_reg  <= ~hsel_reg;
                cnt_reg   <= `SPDTS_CNT1;
                state_reg <= S_TX;
                if (tgt_reg == T_ARR) begin
                  acnt_reg <= acnt_reg + {{(AW-1){1'b0}}, 1'b1};
                end
              end else begin
                oe_reg    <= 1'b0;
                state_reg <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt_reg == `SPDTS_BITS) begin
                oe_reg    <= 1'b0;
                state_reg <= S_TXACK;
              end else begin
                oe_reg  <= ~tx_reg[7];
                tx_reg  <= {tx_reg[6:0], 1'b0};
                cnt_reg <= cnt_reg + `SPDTS_CNT1;
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              hack_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (hack_reg) begin
                oe_reg    <= ~nb_next[7];
                tx_reg    <= {nb_next[6:0], 1'b0};
                hsel_reg  <= ~hsel_reg;
                cnt_reg   <= `SPDTS_CNT1;
                state_reg <= S_TX;
                if (tgt_reg == T_ARR) begin
                  acnt_reg <= acnt_reg + {{(AW-1){1'b0}}, 1'b1};
                end
              end else begin
                // Host no-ack: release the line and wait for a start
                oe_reg    <= 1'b0;
                state_reg <= S_IDLE;
              end
            end
          end
          S_IDLE: begin
            oe_reg <= 1'b0;
          end
          default: begin
            oe_reg    <= 1'b0;
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // spdts_target

// *** spdts_checker.sv ***
// Assertion checker for the module sensor two-wire target
`timescale 1ns/1ps
module spdts_checker #(
  parameter [19:0] WR_CYCLES = 20'h0_03e8 // Write cycle length
) (
  input wire        CLK,          // Clock
  input wire        RSTN,         // Reset, active low
  input wire        SCL_IN,       // Serial clock level
  input wire        SDA_IN,       // Serial data level
  input wire        SDA_OUT,      // Data drive value
  input wire        SDA_OE,       // Data pull enable
  input wire [2:0]  SA_PINS,      // Address straps
  input wire        SA0_HV,       // High-voltage pin flag
  input wire [15:0] AMBIENT_TEMP, // Temperature word
  input wire        ARRAY_BUSY,   // Write cycle running
  input wire [15:0] TS_CONFIG     // Configuration word
);
  reg [19:0] bcnt_reg; // Busy cycles so far
  reg [7:0]  age_reg;  // Cycles since the data pull ended
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Helper counters; age saturates so long idle gaps cannot wrap round
  always @(posedge CLK) begin
    if (!RSTN) begin
      bcnt_reg <= 20'h0_0000;
      age_reg  <= 8'hff;
    end else begin
      bcnt_reg <= ARRAY_BUSY ? bcnt_reg + 20'h0_0001 : 20'h0_0000;
      age_reg  <= SDA_OE ? 8'h00 : ((age_reg == 8'hff) ? age_reg : age_reg + 8'h01);
    end
  end
  sda_out_low_a: assert property (SDA_OUT == 1'b0) else $error("data drive value not low");
  reset_quiet_a: assert property (disable iff (1'b0) !RSTN |=> !SDA_OE && !ARRAY_BUSY && TS_CONFIG == 16'h0000)
    else $error("outputs active in reset");
  oe_settle_a: assert property ($changed(SDA_OE) |-> !SCL_IN && $past(SCL_IN, 2) == 1'b0)
    else $error("data pull changed near a clock high");
  oe_hold_a: assert property ($rose(SCL_IN) |=> $stable(SDA_OE) [*6])
    else $error("data pull moved while clock high");
  busy_stop_a: assert property ($rose(ARRAY_BUSY) |-> SCL_IN && SDA_IN && !SDA_OE)
    else $error("write cycle began without a stop");
  busy_hold_a: assert property ($rose(ARRAY_BUSY) |=> ARRAY_BUSY [*8])
    else $error("write cycle cut short");
  busy_len_a: assert property ($fell(ARRAY_BUSY) |-> (bcnt_reg + 20'h0_0001 >= WR_CYCLES) &&
    (bcnt_reg <= WR_CYCLES + 20'h0_0001)) else $error("write cycle length wrong");
  cfg_ack_a: assert property ($changed(TS_CONFIG) |-> (age_reg < 8'h3c) or (##[0:60] SDA_OE))
    else $error("configuration changed away from an acknowledged byte");
  cover property ($rose(ARRAY_BUSY));
  cover property ($changed(TS_CONFIG));
  cover property ($rose(SDA_OE));
endmodule // spdts_checker

bind spdts_target spdts_checker #(.WR_CYCLES(WR_CYCLES)) chk_i (.CLK(CLK), .RSTN(RSTN), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SA_PINS(SA_PINS), .SA0_HV(SA0_HV),
  .AMBIENT_TEMP(AMBIENT_TEMP), .ARRAY_BUSY(ARRAY_BUSY), .TS_CONFIG(TS_CONFIG));

// *** spdts_host.sv ***
// Bus host model: drives the serial clock and pulls the data wire
`timescale 1ns/1ps
module spdts_host (
  input  wire CLK,   // Bench clock
  input  wire SDA_W, // Resolved data wire
  output reg  SCL,   // Serial clock, idle high
  output reg  SDA_LO // High pulls data low
);
  integer h = 10; // Half bit in clocks; raise it for a slow host
  initial begin
    SCL = 1'b1;
    SDA_LO = 1'b0;
  end
  // Steps land on falling clock edges, away from the sampling edge
  task tk(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  // Data falls while the clock is high; also serves as repeated start
  task start;
    begin
      SDA_LO = 1'b0;
      tk(h / 2);
      SCL = 1'b1;
      tk(h);
      SDA_LO = 1'b1;
      tk(h);
      SCL = 1'b0;
      tk(h / 2);
    end
  endtask
  task stop;
    begin
      SDA_LO = 1'b1;
      tk(h / 2);
      SCL = 1'b1;
      tk(h);
      SDA_LO = 1'b0;
      tk(h);
    end
  endtask
  // Data set mid-low, wire sampled late in the high phase when it has settled
  task slot(input b, output r);
    begin
      SDA_LO = !b;
      tk(h / 2);
      SCL = 1'b1;
      tk(h);
      r = SDA_W;
      SCL = 1'b0;
      tk(h / 2);
    end
  endtask
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) slot(b[i], r);
      slot(1'b1, r);
      ack = !r;
    end
  endtask
  task rbyte(input ack, output [7:0] b);
    integer i;
    reg r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        slot(1'b1, r);
        b[i] = r;
      end
      slot(!ack, r);
    end
  endtask
endmodule // spdts_host

// *** testbench.sv ***
// Self-checking bench for the module sensor two-wire target
`timescale 1ns/1ps
`include "spdts_map.vh"
module testbench;
  reg         CLK = 1'b0;
  reg         RSTN = 1'b0;
  reg  [2:0]  SA_PINS = 3'h0;
  reg         SA0_HV = 1'b0;
  reg  [15:0] AMBIENT_TEMP = 16'h0000;
  wire        SCL, SDA_LO, SDA_OUT, SDA_OE, ARRAY_BUSY;
  wire [15:0] TS_CONFIG;
  wire        sda_w = ~(SDA_LO | SDA_OE); // Pull-up unless a party pulls low
  integer     error_cnt = 0, total_checks = 0, i, cnt = 0, ptr = 0;
  reg  [31:0] seed = 32'h02e4_5639;
  reg  [7:0]  mem [0:255];
  reg  [15:0] treg [0:15];
  reg  [3:0]  prot = 4'h0;
  reg  [2:0]  logical_serial_address;
  reg         a;
  reg  [7:0]  d;
  reg  [15:0] w;
  always #20 CLK = ~CLK;
  // Write cycle shorter than the default, yet long enough that a busy window holds whole bus transfers
  spdts_target #(.WR_CYCLES(20'h0_0258)) uut (.CLK(CLK), .RSTN(RSTN), .SCL_IN(SCL), .SDA_IN(sda_w),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SA_PINS(SA_PINS), .SA0_HV(SA0_HV), .AMBIENT_TEMP(AMBIENT_TEMP),
    .ARRAY_BUSY(ARRAY_BUSY), .TS_CONFIG(TS_CONFIG));
  spdts_host host (.CLK(CLK), .SDA_W(sda_w), .SCL(SCL), .SDA_LO(SDA_LO));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [7:0] ts_a(input rw); ts_a = {`SPDTS_TS_ID, logical_serial_address, rw}; endfunction
  function [7:0] ar_a(input rw); ar_a = {`SPDTS_ARR_ID, logical_serial_address, rw}; endfunction
  task conclude;
    begin
      if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task sel(input [7:0] b, input e);
    begin
      host.wbyte(b, a);
      chk({15'h0000, a}, {15'h0000, e});
    end
  endtask
  task ts_wr(input integer p, input [15:0] v);
    begin
      host.start;
      sel(ts_a(1'b0), 1'b1);
      sel(p[7:0], 1'b1);
      sel(v[15:8], 1'b1);
      sel(v[7:0], 1'b1);
      host.stop;
      ptr = p;
      if (p == 1 || p == 2 || p == 3 || p == 4 || p == 8) treg[p] = v;
    end
  endtask
  // Negative pointer means the latched pointer is reused
  task ts_rd(input integer p, input integer n);
    integer k;
    begin
      host.start;
      if (p >= 0) begin
        sel(ts_a(1'b0), 1'b1);
        sel(p[7:0], 1'b1);
        host.start;
        ptr = p;
      end
      sel(ts_a(1'b1), 1'b1);
      for (k = 0; k < 2 * n; k = k + 1) begin
        host.rbyte(k < 2 * n - 1, d);
        w = (ptr == 5) ? AMBIENT_TEMP : treg[ptr];
        chk({8'h00, d}, {8'h00, k[0] ? w[7:0] : w[15:8]});
      end
      host.stop;
    end
  endtask
  task bz(input e);
    begin
      host.tk(4);
      chk({15'h0000, ARRAY_BUSY}, {15'h0000, e});
    end
  endtask
  task drain;
    integer k;
    begin
      for (k = 0; k < 2000 && ARRAY_BUSY !== 1'b0; k = k + 1) host.tk(1);
      if (ARRAY_BUSY !== 1'b0) begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t write cycle did not end", $time);
        conclude;
      end
    end
  endtask
  task arr_wr(input [7:0] ad, input [7:0] v);
    reg e;
    begin
      e = !prot[ad[7]];
      host.start;
      sel(ar_a(1'b0), 1'b1);
      sel(ad, 1'b1);
      sel(v, e);
      host.stop;
      if (e) mem[ad] = v;
      bz(e);
    end
  endtask
  task arr_rd(input integer ad, input integer n);
    integer k;
    begin
      host.start;
      if (ad >= 0) begin
        sel(ar_a(1'b0), 1'b1);
        sel(ad[7:0], 1'b1);
        host.start;
        cnt = ad;
      end
      sel(ar_a(1'b1), 1'b1);
      for (k = 0; k < n; k = k + 1) begin
        host.rbyte(k < n - 1, d);
        chk({8'h00, d}, {8'h00, mem[cnt]});
        cnt = (cnt + 1) % 256;
      end
      host.stop;
    end
  endtask
  task prot_w(input [2:0] c, input e);
    begin
      host.start;
      sel({`SPDTS_PROT_ID, c, 1'b0}, e);
      sel(8'h00, e);
      sel(8'h00, e);
      host.stop;
      bz(e);
      drain;
      if (e) prot = c[2] ? 4'h0 : (prot | (4'h1 << c[1:0]));
    end
  endtask
  task query(input [2:0] c);
    begin
      host.start;
      sel({`SPDTS_PROT_ID, c, 1'b1}, !prot[c[1:0]]);
      sel(8'h00, 1'b0);
      sel(8'h00, 1'b0);
      host.stop;
    end
  endtask
  // Main sequence: thermal set, address decode, array reads, protection
  initial begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 8'hff;
    for (i = 0; i < 16; i = i + 1) treg[i] = 16'h0000;
    treg[0] = 16'h00ff;
    treg[8] = 16'h0018;
    seed = xs(seed);
    SA_PINS = seed[2:0];
    AMBIENT_TEMP = seed[31:16];
    logical_serial_address = SA_PINS;
    host.tk(8);
    RSTN = 1'b1;
    host.tk(4);
    chk(TS_CONFIG, 16'h0000);
    ts_rd(-1, 1);
    seed = xs(seed);
    ts_wr(1, seed[15:0] & 16'h071f);
    chk(TS_CONFIG, seed[15:0] & 16'h071f);
    host.h = 30;
    ts_rd(1, 2);
    host.h = 10;
    ts_rd(-1, 1);
    for (i = 2; i < 10; i = i + 1) if (i < 5 || i > 7) begin seed = xs(seed); ts_wr(i, seed[15:0]); end
    AMBIENT_TEMP = seed[31:16];
    for (i = 0; i < 10; i = i + 1) ts_rd(i, 1);
    logical_serial_address = ~SA_PINS;
    host.start;
    sel(ts_a(1'b0), 1'b0);
    host.stop;
    SA0_HV = 1'b1;
    ts_rd(-1, 1);
    SA0_HV = 1'b0;
    logical_serial_address = SA_PINS;
    seed = xs(seed);
    arr_wr(8'hff, seed[7:0]);
    host.start;
    sel(ar_a(1'b1), 1'b0);
    host.start;
    sel(ts_a(1'b0), 1'b1);
    host.stop;
    drain;
    arr_wr(8'h00, seed[15:8]);
    drain;
    arr_rd(8'hff, 3);
    arr_rd(-1, 1);
    ts_rd(-1, 1);
    prot_w(3'b001, 1'b1);
    prot_w(3'b001, 1'b0);
    query(3'b001);
    query(3'b000);
    arr_wr(8'h80, seed[23:16]);
    arr_rd(8'hff, 1);
    prot_w(3'b100, 1'b1);
    query(3'b001);
    conclude;
  end
endmodule // testbench
